// ==== hdl/jtsel_pkg.sv ====
// Constants for the debug strap pad multiplexing and test access port selection.
// Function
// [R1] Strap 01b at reset release selects boundary scan.
// [R2] Any other strap value selects on-chip debug.
// [R3] Strap-one pad in other function drives low.
// [R4] Strap-zero pad in strap mode follows pin.
// [R5] Other strap-one mode plus pulled strap-zero gives 01b.
// [R6] Strap-zero mode not 0/15 forces 00b.
// [R7] Observation clock routes to strap-one or chip-select pad.
// [R8] Debugger releases test reset before debug access.
// [R9] No debugger while strap-one carries observation clock.
package jtsel_pkg;
   localparam int         MUX_W            = 4;
   localparam logic [3:0] MUX_STRAP        = 4'h0;
   localparam logic [3:0] MUX_ZERO_ALT     = 4'hf;
   localparam logic [3:0] MUX_OBSCLK       = 4'h1;
   localparam logic [1:0] STRAP_BSCAN      = 2'h1;
   localparam logic [1:0] STRAP_FORCED     = 2'h0;
   typedef enum logic {JTSEL_DEBUG, JTSEL_BSCAN} jtsel_tap_t;
endpackage

// ==== hdl/jtsel_padmux.sv ====
// Pad multiplexing of the two debug strap pads into the registered internal strap value.
`timescale 1ns/1ns
module jtsel_padmux (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] strap_zero_pad_config,
   input  wire logic [3:0] strap_one_pad_config,
   input  wire logic       strap_zero_pin,
   input  wire logic       strap_one_pin,
   output logic      [1:0] strap_internal
);
   typedef struct packed {
      logic [1:0] strap;
   } jtsel_mux_t;
   jtsel_mux_t st, next_st;

   always_comb begin
      next_st = st;
      if (strap_zero_pad_config != jtsel_pkg::MUX_STRAP &&
          strap_zero_pad_config != jtsel_pkg::MUX_ZERO_ALT) begin
         next_st.strap = jtsel_pkg::STRAP_FORCED; // [R6]
      end else begin
         // Strap-zero relies on pull-ups when undriven, so the pin level is taken as is.
         next_st.strap[0] = (strap_zero_pad_config == jtsel_pkg::MUX_STRAP) ?
                            strap_zero_pin : 1'b0; // [R4]
         next_st.strap[1] = (strap_one_pad_config == jtsel_pkg::MUX_STRAP) ?
                            strap_one_pin : 1'b0; // [R3] [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign strap_internal = st.strap;

   property p_forced;
      @(posedge clk) disable iff (!rst_n)
      (strap_zero_pad_config != jtsel_pkg::MUX_STRAP &&
       strap_zero_pad_config != jtsel_pkg::MUX_ZERO_ALT) |=> strap_internal == 2'h0;
   endproperty
   a_forced: assert property (p_forced) else $error("Strap not forced to 00b."); // [R6]
   property p_one_low;
      @(posedge clk) disable iff (!rst_n)
      (strap_one_pad_config != jtsel_pkg::MUX_STRAP) |=> !strap_internal[1];
   endproperty
   a_one_low: assert property (p_one_low) else $error("Strap one not low."); // [R3]
   property p_zero_follow;
      @(posedge clk) disable iff (!rst_n)
      (strap_zero_pad_config == jtsel_pkg::MUX_STRAP) |=>
      strap_internal[0] == $past(strap_zero_pin);
   endproperty
   a_zero_follow: assert property (p_zero_follow) else $error("Strap zero not following."); // [R4]
   property p_bscan_combo;
      @(posedge clk) disable iff (!rst_n)
      (strap_one_pad_config != jtsel_pkg::MUX_STRAP &&
       strap_zero_pad_config == jtsel_pkg::MUX_STRAP && strap_zero_pin) |=>
      strap_internal == 2'h1;
   endproperty
   a_bscan_combo: assert property (p_bscan_combo) else $error("Strap not 01b."); // [R5]
endmodule // jtsel_padmux

// ==== hdl/jtsel_tap_select.sv ====
// Test access port selection from debug straps sampled at test reset release.
`timescale 1ns/1ns
module jtsel_tap_select (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       trst_n,
   input  wire logic [3:0] strap_zero_pad_config,
   input  wire logic [3:0] strap_one_pad_config,
   input  wire logic       strap_zero_pin,
   input  wire logic       strap_one_pin,
   input  wire logic       obsclk_src,
   input  wire logic       obsclk_on_spi_pad,
   output logic            bscan_select,
   output logic            debug_select,
   output logic      [1:0] sampled_strap,
   output logic            strap_one_pad_out,
   output logic            strap_one_pad_oe,
   output logic            spi_chip_select_one_pad_out,
   output logic            spi_chip_select_one_pad_oe
);
   typedef struct packed {
      logic                   trst_prev;
      logic [1:0]             sample;
      logic                   bscan;
      logic                   debug;
      logic                   one_out;
      logic                   one_oe;
      logic                   spi_out;
      logic                   spi_oe;
   } jtsel_state_t;
   jtsel_state_t st, next_st;
   // Test reset counts as already high in reset, so a debugger that holds it released
   // across device reset causes no false edge; the on-chip debug port stays selected.
   localparam jtsel_state_t ST_RESET = '{
      trst_prev : 1'h1,
      sample    : 2'h0,
      bscan     : 1'h0,
      debug     : 1'h1,
      one_out   : 1'h0,
      one_oe    : 1'h0,
      spi_out   : 1'h0,
      spi_oe    : 1'h0
   };
   logic [1:0] strap_internal;
   logic       trst_rise;

   jtsel_padmux u_padmux (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .strap_zero_pad_config (strap_zero_pad_config),
      .strap_one_pad_config  (strap_one_pad_config),
      .strap_zero_pin        (strap_zero_pin),
      .strap_one_pin         (strap_one_pin),
      .strap_internal        (strap_internal)
   );

   // The debugger's reset release is the only sampling moment; straps may change afterwards.
   assign trst_rise = trst_n && !st.trst_prev; // [R8]

   always_comb begin
      jtsel_pkg::jtsel_tap_t pick;
      pick              = jtsel_pkg::JTSEL_DEBUG;
      next_st           = st;
      next_st.trst_prev = trst_n;
      if (trst_rise) begin
         next_st.sample = strap_internal;
         case (strap_internal)
            jtsel_pkg::STRAP_BSCAN: pick = jtsel_pkg::JTSEL_BSCAN; // [R1]
            default:                pick = jtsel_pkg::JTSEL_DEBUG; // [R2]
         endcase
         next_st.bscan = (pick == jtsel_pkg::JTSEL_BSCAN);
         next_st.debug = (pick == jtsel_pkg::JTSEL_DEBUG);
      end
      // Driving the clock on strap one is what risks boundary scan for an attached debugger.
      next_st.one_oe  = !obsclk_on_spi_pad &&
                        strap_one_pad_config == jtsel_pkg::MUX_OBSCLK; // [R7] [R9]
      next_st.one_out = next_st.one_oe && obsclk_src; // [R7]
      next_st.spi_oe  = obsclk_on_spi_pad; // [R7]
      next_st.spi_out = obsclk_on_spi_pad && obsclk_src; // [R7]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign bscan_select                = st.bscan;
   assign debug_select                = st.debug;
   assign sampled_strap               = st.sample;
   assign strap_one_pad_out           = st.one_out;
   assign strap_one_pad_oe            = st.one_oe;
   assign spi_chip_select_one_pad_out = st.spi_out;
   assign spi_chip_select_one_pad_oe  = st.spi_oe;

   // A release in the first cycle after device reset has no history to compare with,
   // so these checks, like the logic, only count releases seen from a running clock.
   property p_bscan;
      @(posedge clk) disable iff (!rst_n)
      trst_n && !$past(trst_n) && $past(rst_n) && strap_internal == jtsel_pkg::STRAP_BSCAN
      |=> bscan_select && !debug_select;
   endproperty
   a_bscan: assert property (p_bscan) // [R1]
      else $error("Boundary scan not selected.");

   property p_debug;
      @(posedge clk) disable iff (!rst_n)
      trst_n && !$past(trst_n) && $past(rst_n) && strap_internal != jtsel_pkg::STRAP_BSCAN
      |=> debug_select && !bscan_select;
   endproperty
   a_debug: assert property (p_debug) // [R2]
      else $error("Debug port not selected.");

   property p_catch;
      @(posedge clk) disable iff (!rst_n)
      trst_n && !$past(trst_n) && $past(rst_n)
      |=> sampled_strap == $past(strap_internal);
   endproperty
   a_catch: assert property (p_catch) // [R1] [R2]
      else $error("Strap value not caught at test reset release.");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      !(trst_n && !$past(trst_n) && $past(rst_n))
      |=> $stable(bscan_select) && $stable(debug_select);
   endproperty
   a_hold: assert property (p_hold) // [R8]
      else $error("Selection changed without reset release.");

   property p_sample_hold;
      @(posedge clk) disable iff (!rst_n)
      !(trst_n && !$past(trst_n) && $past(rst_n))
      |=> $stable(sampled_strap);
   endproperty
   a_sample_hold: assert property (p_sample_hold) // [R8]
      else $error("Sampled strap changed without reset release.");

   property p_one_hot;
      @(posedge clk) disable iff (!rst_n)
      bscan_select != debug_select;
   endproperty
   a_one_hot: assert property (p_one_hot) // [R1] [R2]
      else $error("Both or neither access port selected.");

   property p_select_match;
      @(posedge clk) disable iff (!rst_n)
      bscan_select == (sampled_strap == jtsel_pkg::STRAP_BSCAN);
   endproperty
   a_select_match: assert property (p_select_match) // [R1] [R2]
      else $error("Selection does not match the sampled strap.");

   property p_forced_path;
      @(posedge clk) disable iff (!rst_n)
      trst_n && !$past(trst_n) && $past(rst_n) &&
      $past(strap_zero_pad_config) != jtsel_pkg::MUX_STRAP &&
      $past(strap_zero_pad_config) != jtsel_pkg::MUX_ZERO_ALT
      |=> debug_select && sampled_strap == jtsel_pkg::STRAP_FORCED;
   endproperty
   a_forced_path: assert property (p_forced_path) // [R6]
      else $error("Forced strap value did not select the debug port.");

   property p_one_path;
      @(posedge clk) disable iff (!rst_n)
      trst_n && !$past(trst_n) && $past(rst_n) &&
      $past(strap_one_pad_config) != jtsel_pkg::MUX_STRAP
      |=> !sampled_strap[1];
   endproperty
   a_one_path: assert property (p_one_path) // [R3]
      else $error("Strap one sampled high while its pad serves another function.");

   property p_obs_exclusive;
      @(posedge clk) disable iff (!rst_n)
      obsclk_on_spi_pad
      |=> spi_chip_select_one_pad_oe && !strap_one_pad_oe;
   endproperty
   a_obs_exclusive: assert property (p_obs_exclusive) // [R7]
      else $error("Clock on both pads.");

   property p_spi_follow;
      @(posedge clk) disable iff (!rst_n)
      obsclk_on_spi_pad
      |=> spi_chip_select_one_pad_out == $past(obsclk_src);
   endproperty
   a_spi_follow: assert property (p_spi_follow) // [R7]
      else $error("Chip-select pad does not carry the clock.");

   property p_spi_idle;
      @(posedge clk) disable iff (!rst_n)
      !obsclk_on_spi_pad
      |=> !spi_chip_select_one_pad_oe && !spi_chip_select_one_pad_out;
   endproperty
   a_spi_idle: assert property (p_spi_idle) // [R7]
      else $error("Chip-select pad driven without the clock routed there.");

   property p_one_clock;
      @(posedge clk) disable iff (!rst_n)
      !obsclk_on_spi_pad && strap_one_pad_config == jtsel_pkg::MUX_OBSCLK
      |=> strap_one_pad_oe && strap_one_pad_out == $past(obsclk_src);
   endproperty
   a_one_clock: assert property (p_one_clock) // [R7]
      else $error("Strap one pad does not carry the clock.");

   property p_one_default;
      @(posedge clk) disable iff (!rst_n)
      strap_one_pad_config != jtsel_pkg::MUX_OBSCLK
      |=> !strap_one_pad_oe && !strap_one_pad_out;
   endproperty
   a_one_default: assert property (p_one_default) // [R7]
      else $error("Strap one pad driven outside the clock mode.");

   // Main scenarios: both selections, the alternative strap-zero mode and both clock pads.
   c_bscan: cover property (@(posedge clk) disable iff (!rst_n) $rose(bscan_select));
   c_debug: cover property (@(posedge clk) disable iff (!rst_n)
                            trst_n && !$past(trst_n) && strap_internal == 2'h0);
   c_obs_one: cover property (@(posedge clk) disable iff (!rst_n) strap_one_pad_oe);
   c_obs_spi: cover property (@(posedge clk) disable iff (!rst_n) spi_chip_select_one_pad_oe);
   c_alt_zero: cover property (@(posedge clk) disable iff (!rst_n)
                               trst_n && !$past(trst_n) &&
                               $past(strap_zero_pad_config) == jtsel_pkg::MUX_ZERO_ALT);
endmodule // jtsel_tap_select

// ==== verif/jtsel_debugger.sv ====
// Debugger model that drives the test reset line.
`timescale 1ns/1ns
module jtsel_debugger (
   input  wire logic clk,
   output logic      trst_n
);
   initial trst_n = 1'h0;
   // Reset is released before each access, so the straps are caught anew.
   task automatic attach();
      @(posedge clk);
      #1 trst_n = 1'h0;
      repeat (3) @(posedge clk);
      #1 trst_n = 1'h1;
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule // jtsel_debugger

// ==== verif/tb_jtsel_tap_select.sv ====
// Testbench for test access port selection from the debug straps.
`timescale 1ns/1ns
module tb_jtsel_tap_select;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        trst_n;
   logic [3:0]  cfg0 = 4'h0;
   logic [3:0]  cfg1 = 4'h0;
   logic        pin0 = 1'h1;
   logic        pin1 = 1'h0;
   logic        osrc = 1'h0;
   logic        ospi = 1'h0;
   logic        bsel, dsel, p1o, p1e, spo, spe;
   logic [1:0]  smp;
   int          miscompares = 0;
   int          check_count = 0;
   // Row: zero mode, one mode, zero pin, one pin, expected strap, boundary scan.
   logic [12:0] rows [10] = '{13'h0013, 13'h001e, 13'h0000, 13'h000c, 13'h003b,
                              13'h00f3, 13'h0638, 13'h1e38, 13'h1e1c, 13'h0013};
   always #4 clk = ~clk;
   jtsel_debugger dbg (.clk(clk), .trst_n(trst_n));
   jtsel_tap_select dut (.clk(clk), .rst_n(rst_n), .trst_n(trst_n),
      .strap_zero_pad_config(cfg0), .strap_one_pad_config(cfg1),
      .strap_zero_pin(pin0), .strap_one_pin(pin1), .obsclk_src(osrc),
      .obsclk_on_spi_pad(ospi), .bscan_select(bsel), .debug_select(dsel),
      .sampled_strap(smp), .strap_one_pad_out(p1o), .strap_one_pad_oe(p1e),
      .spi_chip_select_one_pad_out(spo), .spi_chip_select_one_pad_oe(spe));
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %b, wanted %b", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // The run has no open handshake, so one overall limit cuts any hang short.
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 chk({bsel, dsel, smp}, 4'h4);
      rst_n = 1'h1;
      for (int i = 0; i < 10; i++) begin
         {cfg0, cfg1, pin0, pin1} = rows[i][12:3];
         dbg.attach();
         chk({2'h0, smp}, {2'h0, rows[i][2:1]});
         chk({2'h0, bsel, dsel}, {2'h0, rows[i][0], ~rows[i][0]});
      end
      // Straps moving with no test reset release must not change the choice.
      pin1 = 1'h1;
      repeat (4) @(posedge clk);
      #1 chk({bsel, dsel, smp}, 4'h9);
      // No debugger attaches from here on, as strap one now carries the clock.
      cfg1 = 4'h1;
      osrc = 1'h1;
      repeat (3) @(posedge clk);
      #1 chk({2'h0, p1e, p1o}, 4'h3);
      ospi = 1'h1;
      repeat (3) @(posedge clk);
      #1 chk({1'h0, spe, spo, p1e}, 4'h6);
      rst_n = 1'h0;
      #2 chk({bsel, dsel, smp}, 4'h4);
      // Test reset is still released here, so leaving reset must not count as an edge.
      @(posedge clk);
      #1 rst_n = 1'h1;
      repeat (3) @(posedge clk);
      #1 chk({bsel, dsel, smp}, 4'h4);
      report_and_stop();
   end
endmodule // tb_jtsel_tap_select
